/* File: bench/cbl_core_properties.sv */
`timescale 1ns/1ps
module cbl_core_props (
    input wire logic              clk_i,     // cpu clock
    input wire logic              sys_rst_i, // async reset
    input wire logic              cpu_en_i,  // clock enable
    input wire logic              start_i,   // issue
    input wire cbl_pkg::cbl_req_t req_i,     // instruction
    input wire logic              busy_o,    // executing
    input wire logic              done_o,    // done pulse
    input wire logic              carry_o,   // carry
    input wire logic [7:0]        wr_data_o, // write byte
    input wire logic              wr_en_o,   // write pulse
    input wire logic [2:0]        bytes_o,   // length
    input wire logic [3:0]        cycles_o   // cycles
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic       take;
    logic       lgc;
    logic       run_q;
    logic [4:0] cnt_q;
    assign take = start_i && cpu_en_i && !busy_o;
    assign lgc  = take && req_i.op <= cbl_pkg::CBL_OP_XOR && req_i.src != cbl_pkg::CBL_SRC_CY;
    // enabled edges since the taking edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
            cnt_q <= 5'h00;
        end else if (take) begin
            // the taking edge is the first counted cycle
            run_q <= 1'b1;
            cnt_q <= 5'h01;
        end else if (done_o) begin
            run_q <= 1'b0;
        end else if (run_q && cpu_en_i) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    a_take_busy: assert property (take |=> busy_o)
        else $error("busy not raised after start");
    a_done_count: assert property (done_o |-> cnt_q == {1'b0, cycles_o})
        else $error("done edge count differs from cycles");
    a_saddr_time: assert property (lgc && req_i.src == cbl_pkg::CBL_SRC_SADDR |=>
        bytes_o == 3'h3 && cycles_o == ($past(req_i.hs_ram) ? 4'h6 : 4'h7))
        else $error("short direct timing wrong");
    a_sfr_time: assert property (lgc && req_i.src == cbl_pkg::CBL_SRC_SFR |=>
        bytes_o == 3'h3 && cycles_o == 4'h7) else $error("special register timing wrong");
    a_acc_time: assert property (lgc && req_i.src == cbl_pkg::CBL_SRC_ACC |=>
        bytes_o == 3'h2 && cycles_o == 4'h4) else $error("accumulator timing wrong");
    a_psw_time: assert property (lgc && req_i.src == cbl_pkg::CBL_SRC_PSW |=>
        bytes_o == 3'h3 && cycles_o == 4'h7) else $error("status word timing wrong");
    a_ptr_time: assert property (lgc && req_i.src == cbl_pkg::CBL_SRC_HL |=>
        bytes_o == 3'h2 && cycles_o == ($past(req_i.hs_ram) ? 4'h6 : 4'h7))
        else $error("pointer form timing wrong");
    a_cy_time: assert property (take && (req_i.src == cbl_pkg::CBL_SRC_CY ||
        req_i.op == cbl_pkg::CBL_OP_NOT) |=> bytes_o == 3'h1 && cycles_o == 4'h2)
        else $error("carry form timing wrong");
    a_carry_moves: assert property ($changed(carry_o) |-> done_o)
        else $error("carry changed outside completion");
    a_wr_pulse: assert property (wr_en_o |-> done_o ##1 !wr_en_o)
        else $error("write pulse not one cycle with done");
    cover property (lgc && req_i.src == cbl_pkg::CBL_SRC_HL && req_i.hs_ram);
    cover property (done_o && wr_en_o);
    cover property (start_i && busy_o);
endmodule : cbl_core_props
bind cbl_core cbl_core_props i_cbl_core_props (.clk_i, .sys_rst_i, .cpu_en_i, .start_i,
    .req_i, .busy_o, .done_o, .carry_o, .wr_data_o, .wr_en_o, .bytes_o, .cycles_o);

/* File: bench/tb_cbl_core.sv */
`timescale 1ns/1ps
module tb_cbl_core;
    logic              clk_i;
    logic              sys_rst_i;
    logic              start_i;
    logic              cpu_en_i;
    cbl_pkg::cbl_req_t req_i;
    cbl_pkg::cbl_req_t r;
    logic              busy_o, done_o, carry_o, wr_en_o, cy;
    logic [7:0]        wr_data_o;
    logic [2:0]        bytes_o;
    logic [3:0]        cycles_o;
    int                failures, total_checks, ticks;
    cbl_core i_cbl_core (.clk_i, .sys_rst_i, .cpu_en_i, .start_i, .req_i, .busy_o,
        .done_o, .carry_o, .wr_data_o, .wr_en_o, .bytes_o, .cycles_o);
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic stop_test;
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic chk_tim(input cbl_pkg::cbl_timing_t got, input cbl_pkg::cbl_timing_t exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_tim
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte
    function automatic cbl_pkg::cbl_timing_t exp_tim(input cbl_pkg::cbl_req_t q);
        logic l;
        l = q.op <= cbl_pkg::CBL_OP_XOR;
        if (q.src == cbl_pkg::CBL_SRC_CY || q.op == cbl_pkg::CBL_OP_NOT) return {3'h1, 4'h2};
        case (q.src)
            cbl_pkg::CBL_SRC_SADDR: return l ? {3'h3, q.hs_ram ? 4'h6 : 4'h7}
                                             : {3'h2, q.hs_ram ? 4'h4 : 4'h6};
            cbl_pkg::CBL_SRC_SFR:   return {3'h3, l ? 4'h7 : 4'h8};
            cbl_pkg::CBL_SRC_ACC:   return {3'h2, 4'h4};
            cbl_pkg::CBL_SRC_PSW:   return l ? {3'h3, 4'h7} : {3'h2, 4'h6};
            default:                return {3'h2, q.hs_ram ? 4'h6 : (l ? 4'h7 : 4'h8)};
        endcase
    endfunction : exp_tim
    // entered 1 ns after an edge; when intr is set, a refused start is slipped in at the third edge, the second after the taking edge, if still busy
    // stall drops the cpu enable at random, so only enabled edges are counted
    task automatic run(input cbl_pkg::cbl_req_t q, input bit intr, input bit stall);
        cbl_pkg::cbl_timing_t t;
        logic       b, ecy, ewr, isc;
        logic [7:0] ed;
        int         k, n;
        t = exp_tim(q);
        b = q.operand[q.bit_sel];
        isc = q.src == cbl_pkg::CBL_SRC_CY;
        ewr = !isc && (q.op == cbl_pkg::CBL_OP_SET || q.op == cbl_pkg::CBL_OP_CLR);
        ed = q.operand;
        ed[q.bit_sel] = q.op == cbl_pkg::CBL_OP_SET;
        case (q.op)
            cbl_pkg::CBL_OP_AND: ecy = cy & b;
            cbl_pkg::CBL_OP_OR:  ecy = cy | b;
            cbl_pkg::CBL_OP_XOR: ecy = cy ^ b;
            cbl_pkg::CBL_OP_SET: ecy = isc ? 1'b1 : cy;
            cbl_pkg::CBL_OP_CLR: ecy = isc ? 1'b0 : cy;
            default:             ecy = ~cy;
        endcase
        req_i = q;
        start_i = 1'b1;
        @(posedge clk_i);
        #1;
        start_i = 1'b0;
        chk_tim({bytes_o, cycles_o}, t);
        k = 1;
        n = 0;
        while (done_o !== 1'b1 && n < 60) begin
            start_i = intr && n == 1;
            cpu_en_i = !stall || $urandom_range(1) == 1;
            if (intr) req_i.src = cbl_pkg::CBL_SRC_CY;
            @(posedge clk_i);
            #1;
            k += int'(cpu_en_i);
            n++;
        end
        chk_byte(8'(k), {4'h0, t.cycles});
        chk_byte({7'h00, carry_o}, {7'h00, ecy});
        chk_byte({7'h00, wr_en_o}, {7'h00, ewr});
        if (ewr) chk_byte(wr_data_o, ed);
        cy = ecy;
    endtask : run
    always @(posedge clk_i) begin
        ticks++;
        if (ticks > 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        sys_rst_i = 1'b1;
        start_i = 1'b0;
        cpu_en_i = 1'b1;
        req_i = '0;
        cy = 1'b0;
        failures = 0;
        total_checks = 0;
        ticks = 0;
        void'($urandom(77724));
        repeat (6) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk_byte({7'h00, carry_o}, 8'h00);
        // table of every form first, then random operands and forms
        for (int i = 0; i < 260; i++) begin
            r = 18'($urandom);
            r.op = cbl_pkg::cbl_op_t'(i < 53 ? 3'(i < 50 ? i % 5 : i - 47)
                                             : 3'($urandom_range(5)));
            r.src = cbl_pkg::cbl_src_t'(i < 50 ? 3'((i / 5) % 5) : 3'($urandom_range(4)));
            if (i < 50) r.hs_ram = i >= 25;
            if (r.op == cbl_pkg::CBL_OP_NOT || (i >= 50 && r.op >= cbl_pkg::CBL_OP_SET
                && (i < 53 || $urandom_range(3) == 0))) r.src = cbl_pkg::CBL_SRC_CY;
            run(r, i % 7 == 3, i % 4 == 1);
        end
        stop_test();
    end
endmodule : tb_cbl_core

/* File: include/cbl_pkg.sv */
package cbl_pkg;

    // operand source of a bit instruction
    typedef enum logic [2:0] {
        CBL_SRC_SADDR = 3'h0,
        CBL_SRC_SFR   = 3'h1,
        CBL_SRC_ACC   = 3'h2,
        CBL_SRC_PSW   = 3'h3,
        CBL_SRC_HL    = 3'h4,
        CBL_SRC_CY    = 3'h5
    } cbl_src_t;

    // operation performed
    typedef enum logic [2:0] {
        CBL_OP_AND = 3'h0,
        CBL_OP_OR  = 3'h1,
        CBL_OP_XOR = 3'h2,
        CBL_OP_SET = 3'h3,
        CBL_OP_CLR = 3'h4,
        CBL_OP_NOT = 3'h5
    } cbl_op_t;

    typedef struct packed {
        cbl_op_t  op;
        cbl_src_t src;
        logic     hs_ram;
        logic [2:0] bit_sel;
        logic [7:0] operand;
    } cbl_req_t;

    typedef struct packed {
        logic [2:0] bytes;
        logic [3:0] cycles;
    } cbl_timing_t;

    localparam logic [2:0] CBL_BYTES_1 = 3'h1;
    localparam logic [2:0] CBL_BYTES_2 = 3'h2;
    localparam logic [2:0] CBL_BYTES_3 = 3'h3;
    localparam logic [3:0] CBL_CYC_2   = 4'h2;
    localparam logic [3:0] CBL_CYC_4   = 4'h4;
    localparam logic [3:0] CBL_CYC_6   = 4'h6;
    localparam logic [3:0] CBL_CYC_7   = 4'h7;
    localparam logic [3:0] CBL_CYC_8   = 4'h8;
    localparam logic       CBL_CY_RST  = 1'b0;
    localparam logic [7:0] CBL_BYTE_RST = 8'h00;

endpackage : cbl_pkg

/* File: verilog/cbl_alu.sv */
`timescale 1ns/1ps
module cbl_alu (
    input  wire cbl_pkg::cbl_req_t req_i,     // decoded instruction
    input  wire logic              cy_i,      // current carry
    output logic                   cy_o,      // new carry
    output logic [7:0]             byte_o,    // operand with bit forced
    output logic                   wr_o       // operand byte is written back
);
    logic sel_bit;
    always_comb begin
        sel_bit = req_i.operand[req_i.bit_sel];
        cy_o    = cy_i;
        byte_o  = req_i.operand;
        wr_o    = 1'b0;
        unique case (req_i.op)
            cbl_pkg::CBL_OP_AND: cy_o = cy_i & sel_bit;
            cbl_pkg::CBL_OP_OR:  cy_o = cy_i | sel_bit;
            cbl_pkg::CBL_OP_XOR: cy_o = cy_i ^ sel_bit;
            cbl_pkg::CBL_OP_NOT: cy_o = ~cy_i;
            cbl_pkg::CBL_OP_SET: begin
                if (req_i.src == cbl_pkg::CBL_SRC_CY) begin
                    cy_o = 1'b1;
                end else begin
                    byte_o[req_i.bit_sel] = 1'b1;
                    wr_o = 1'b1;
                end
            end
            default: begin
                if (req_i.src == cbl_pkg::CBL_SRC_CY) begin
                    cy_o = 1'b0;
                end else begin
                    byte_o[req_i.bit_sel] = 1'b0;
                    wr_o = 1'b1;
                end
            end
        endcase
    end
endmodule : cbl_alu

/* File: verilog/cbl_core.sv */
`timescale 1ns/1ps
// Function
// - carry-AND with short-direct bit; 3 bytes, 6 cycles high-speed RAM, else 7.
// - carry-OR with operand bit; lengths and cycles as the AND form.
// - carry-XOR with operand bit; lengths and cycles as the AND form.
// - special-register bit form: 3 bytes, 7 cycles, no fast variant.
// - accumulator bit form: 2 bytes, 4 cycles.
// - status-word bit form: 3 bytes, 7 cycles.
// - pointer-addressed bit form: 2 bytes, 6 cycles fast RAM, else 7.
// - shorter count for high-speed RAM or no data access.
// - longer count when the operand lies outside high-speed RAM.
// - one counted cycle equals one cpu clock edge with cpu_en_i high.
// - counts hold for code fetched from internal ROM.
module cbl_core (
    input  wire logic              clk_i,       // cpu clock
    input  wire logic              sys_rst_i,   // async reset, active high
    input  wire logic              cpu_en_i,    // one-cycle cpu clock enable
    input  wire logic              start_i,     // issue instruction, pulse
    input  wire cbl_pkg::cbl_req_t req_i,       // decoded instruction
    output logic                   busy_o,      // executing
    output logic                   done_o,      // last cycle pulse
    output logic                   carry_o,     // carry flag
    output logic [7:0]             wr_data_o,   // byte to write back
    output logic                   wr_en_o,     // write-back pulse
    output logic [2:0]             bytes_o,     // length of last instruction
    output logic [3:0]             cycles_o     // cycles of last instruction
);
    typedef enum logic [0:0] {
        CBL_IDLE = 1'b0,
        CBL_EXEC = 1'b1
    } cbl_state_t;

    cbl_state_t           state_q;
    cbl_pkg::cbl_req_t    req_q;
    cbl_pkg::cbl_timing_t tim;
    cbl_pkg::cbl_timing_t tim_q;
    logic [3:0]           cnt_q;
    logic                 cy_n;
    logic [7:0]           byte_n;
    logic                 wr_n;

    cbl_timing u_timing (
        .req_i    (req_i),
        .timing_o (tim)
    );

    // result computed from latched instruction so the carry is sampled at completion
    cbl_alu u_alu (
        .req_i  (req_q),
        .cy_i   (carry_o),
        .cy_o   (cy_n),
        .byte_o (byte_n),
        .wr_o   (wr_n)
    );

    // starts are ignored while busy; counts assume code in internal ROM
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= CBL_IDLE;
            cnt_q   <= 4'h0;
        end else if (cpu_en_i) begin
            unique case (state_q)
                CBL_IDLE: begin
                    if (start_i) begin
                        state_q <= CBL_EXEC;
                        cnt_q   <= tim.cycles - 4'h1;
                    end
                end
                CBL_EXEC: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= CBL_IDLE;
                    end
                    cnt_q <= cnt_q - 4'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_q    <= '0;
            tim_q    <= '0;
            bytes_o  <= 3'h0;
            cycles_o <= 4'h0;
        end else if (cpu_en_i && state_q == CBL_IDLE && start_i) begin
            req_q    <= req_i;
            tim_q    <= tim;
            bytes_o  <= tim.bytes;
            cycles_o <= tim.cycles;
        end
    end

    wire fin = cpu_en_i && state_q == CBL_EXEC && cnt_q == 4'h1;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            carry_o   <= cbl_pkg::CBL_CY_RST;
            wr_data_o <= cbl_pkg::CBL_BYTE_RST;
            wr_en_o   <= 1'b0;
            done_o    <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            done_o  <= fin;
            wr_en_o <= fin & wr_n;
            if (fin) begin
                carry_o   <= cy_n;
                wr_data_o <= byte_n;
            end
            if (cpu_en_i && state_q == CBL_IDLE && start_i) begin
                busy_o <= 1'b1;
            end else if (fin) begin
                busy_o <= 1'b0;
            end
        end
    end
endmodule : cbl_core

/* File: verilog/cbl_timing.sv */
`timescale 1ns/1ps
module cbl_timing (
    input  wire cbl_pkg::cbl_req_t    req_i,     // decoded instruction
    output cbl_pkg::cbl_timing_t      timing_o   // byte length and cycles
);
    always_comb begin
        timing_o.bytes  = cbl_pkg::CBL_BYTES_3;
        timing_o.cycles = cbl_pkg::CBL_CYC_7;
        if (req_i.op == cbl_pkg::CBL_OP_SET || req_i.op == cbl_pkg::CBL_OP_CLR) begin
            unique case (req_i.src)
                cbl_pkg::CBL_SRC_SADDR: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = req_i.hs_ram ? cbl_pkg::CBL_CYC_4 : cbl_pkg::CBL_CYC_6;
                end
                cbl_pkg::CBL_SRC_SFR: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_3;
                    timing_o.cycles = cbl_pkg::CBL_CYC_8;
                end
                cbl_pkg::CBL_SRC_ACC: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = cbl_pkg::CBL_CYC_4;
                end
                cbl_pkg::CBL_SRC_PSW: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = cbl_pkg::CBL_CYC_6;
                end
                cbl_pkg::CBL_SRC_HL: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = req_i.hs_ram ? cbl_pkg::CBL_CYC_6 : cbl_pkg::CBL_CYC_8;
                end
                default: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_1;
                    timing_o.cycles = cbl_pkg::CBL_CYC_2;
                end
            endcase
        end else if (req_i.op == cbl_pkg::CBL_OP_NOT || req_i.src == cbl_pkg::CBL_SRC_CY) begin
            timing_o.bytes  = cbl_pkg::CBL_BYTES_1;
            timing_o.cycles = cbl_pkg::CBL_CYC_2;
        end else begin
            unique case (req_i.src)
                cbl_pkg::CBL_SRC_SADDR: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_3;
                    timing_o.cycles = req_i.hs_ram ? cbl_pkg::CBL_CYC_6
                                                   : cbl_pkg::CBL_CYC_7;
                end
                cbl_pkg::CBL_SRC_SFR: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_3;
                    timing_o.cycles = cbl_pkg::CBL_CYC_7;
                end
                cbl_pkg::CBL_SRC_ACC: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = cbl_pkg::CBL_CYC_4;
                end
                cbl_pkg::CBL_SRC_PSW: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_3;
                    timing_o.cycles = cbl_pkg::CBL_CYC_7;
                end
                default: begin
                    timing_o.bytes  = cbl_pkg::CBL_BYTES_2;
                    timing_o.cycles = req_i.hs_ram ? cbl_pkg::CBL_CYC_6
                                                   : cbl_pkg::CBL_CYC_7;
                end
            endcase
        end
    end
endmodule : cbl_timing
